// [include/rtc_pkg.sv]
// Constants, encodings and reset values of the I2C real-time clock core
package rtc_pkg;
	// ****************************************
	// Bus target address and register map
	// ****************************************
	localparam logic [6:0] RTC_DEV_ADDR = 7'h51;
	localparam logic [4:0] RTC_OFS_CONTROL = 5'h00;
	localparam logic [4:0] RTC_OFS_FREQ = 5'h02;
	localparam logic [4:0] RTC_OFS_SECONDS = 5'h04;
	localparam logic [4:0] RTC_OFS_YEAR = 5'h0a;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int RTC_BIT_CAP = 0;
	localparam int RTC_BIT_H12 = 1;
	localparam int RTC_BIT_FLAG = 7;
	localparam int RTC_BIT_PM = 5;
	localparam int RTC_BIT_MODE = 7;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RTC_RST_CONTROL = 8'h00;
	localparam logic [7:0] RTC_RST_FREQ = 8'h00;
	localparam logic [7:0] RTC_RST_SECONDS = 8'h80;
	localparam logic [7:0] RTC_RST_DAY = 8'h01;
	localparam logic [7:0] RTC_RST_MONTH = 8'h01;
	localparam logic [7:0] RTC_RST_ZERO = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int RTC_OSC_HZ = 32768;
	localparam int RTC_CORR_MODE0_HOURS = 2;
	localparam int RTC_CORR_MODE1_MINUTES = 4;
	localparam int RTC_CORR_MODE0_S = RTC_CORR_MODE0_HOURS * 3600;
	localparam int RTC_CORR_MODE1_S = RTC_CORR_MODE1_MINUTES * 60;
	// ****************************************
	// Bus target states, Gray along the usual path
	// ****************************************
	typedef enum logic [2:0] {
		RTC_IDLE = 3'b000,
		RTC_ADDR = 3'b001,
		RTC_ADDR_ACK = 3'b011,
		RTC_WDATA = 3'b010,
		RTC_WACK = 3'b110,
		RTC_RDATA = 3'b111,
		RTC_RACK = 3'b101
	} rtc_state_t;
endpackage : rtc_pkg

// [hdl/rtc_core.sv]
// I2C-bus target and BCD calendar with digital frequency correction
//
// Behaviour
// R1: write is address, pointer, then stored data bytes
// R2: control 03h selects 12-hour and 12.5 pF
// R3: control 02h selects 12-hour and 7 pF
// R4: seconds at pointer 4, then minutes to year
// R5: seconds MSB is clock-integrity flag, zero valid
// R6: 12-hour hours are BCD, bit 5 marks PM
// R7: read is pointer write, repeated start, read address
// R8: read burst returns time registers, pointer advances
// R9: minutes, days, month, year kept packed BCD
// R10: weekday index stored unchanged, advances daily
// R11: frequency correction value lives at register 2
// R12: correction shortens or lengthens one chosen second
// R13: mode 0 corrects once every 2 hours
// R14: mode 1 corrects once every 4 minutes
// R15: clock output carries the uncorrected oscillator
// R16: time frozen during access, pending increment later
// R17: month lengths automatic, year divisible 4 leaps
// R18: acknowledge address and writes, read until NACK
`timescale 1ns/1ps
module rtc_core
	import rtc_pkg::*;
#(
	parameter int TICKS_PER_SEC = RTC_OSC_HZ,
	parameter int CORR_MODE0_SEC = RTC_CORR_MODE0_S,
	parameter int CORR_MODE1_SEC = RTC_CORR_MODE1_S
)(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic osc_i,
	output logic oscillator_output_pin_o,
	output logic hour12_mode_o,
	output logic cap_sel_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] osc_s;
		rtc_state_t state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [4:0] ptr;
		logic first;
		logic nack;
		logic drv;
		logic busy;
		logic pend;
		logic [7:0] ctrl;
		logic [7:0] freq;
		logic [6:0][7:0] tm;
		logic [15:0] tick;
		logic [12:0] corr;
		logic fix;
		logic clk_out;
	} rtc_regs_t;

	rtc_regs_t st_r;
	rtc_regs_t st_nxt;

	localparam logic [12:0] CORR0_LAST = 13'(CORR_MODE0_SEC - 1);
	localparam logic [12:0] CORR1_LAST = 13'(CORR_MODE1_SEC - 1);
	localparam logic [16:0] TPS = 17'(TICKS_PER_SEC);

	// ****************************************
	// Calendar helpers
	// ****************************************
	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v == last)
			bcd_inc = {1'b1, first};
		else if (v[3:0] == 4'h9)
			bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	function automatic logic [7:0] month_last(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == 8'h02)
			month_last = leap ? 8'h29 : 8'h28;
		else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09
			|| mon == 8'h11)
			month_last = 8'h30;
		else
			month_last = 8'h31;
	endfunction : month_last

	function automatic logic [7:0] reg_read(input rtc_regs_t s);
		if (s.ptr == RTC_OFS_CONTROL)
			reg_read = s.ctrl;
		else if (s.ptr == RTC_OFS_FREQ)
			reg_read = s.freq;
		else if (s.ptr >= RTC_OFS_SECONDS && s.ptr <= RTC_OFS_YEAR)
			reg_read = s.tm[3'(s.ptr - RTC_OFS_SECONDS)];
		else
			reg_read = 8'h00;
	endfunction : reg_read

	// ****************************************
	// Bus events
	// ****************************************
	logic scl_rise, scl_fall, start_c, stop_c, osc_rise;
	logic sec_done, inc_now, wr_en;
	logic [16:0] sec_len;
	logic [8:0] c_min, c_day, c_mon, c_yr;
	logic [7:0] h_nxt;
	logic h_carry;
	// Function results are held here so that slices of them stay legal
	logic [7:0] rd_byte;
	logic [8:0] h12_inc, sec_inc;

	assign scl_rise = st_r.scl_s[1] & ~st_r.scl_s[2];
	assign scl_fall = ~st_r.scl_s[1] & st_r.scl_s[2];
	assign start_c = st_r.scl_s[1] & st_r.scl_s[2]
		& ~st_r.sda_s[1] & st_r.sda_s[2];
	assign stop_c = st_r.scl_s[1] & st_r.scl_s[2]
		& st_r.sda_s[1] & ~st_r.sda_s[2];
	assign osc_rise = st_r.osc_s[1] & ~st_r.osc_s[2];
	assign wr_en = st_r.state == RTC_WDATA && scl_fall
		&& st_r.bitcnt == 4'd8 && !st_r.first;
	// Chosen second runs short for a positive value, long for negative
	assign sec_len = st_r.fix
		? TPS - {{10{st_r.freq[6]}}, st_r.freq[6:0]} : TPS; // R12
	assign sec_done = osc_rise && 17'(st_r.tick) == sec_len - 17'd1;
	// Increments wait while the bus is busy so a burst stays coherent
	assign inc_now = st_r.pend && !st_r.busy; // R16

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.scl_s = {st_r.scl_s[1:0], scl_i};
		st_nxt.sda_s = {st_r.sda_s[1:0], sda_i};
		st_nxt.osc_s = {st_r.osc_s[1:0], osc_i};
		st_nxt.clk_out = st_r.osc_s[1]; // R15
		c_min = bcd_inc(st_r.tm[1], 8'h59, 8'h00); // R9
		c_day = bcd_inc(st_r.tm[3], month_last(st_r.tm[5], st_r.tm[6]),
			8'h01); // R17
		c_mon = bcd_inc(st_r.tm[5], 8'h12, 8'h01);
		c_yr = bcd_inc(st_r.tm[6], 8'h99, 8'h00);
		rd_byte = reg_read(st_r);
		h12_inc = bcd_inc({3'b000, st_r.tm[2][4:0]}, 8'h12, 8'h01);
		sec_inc = bcd_inc({1'b0, st_r.tm[0][6:0]}, 8'h59, 8'h00);
		h_carry = 1'b0;
		h_nxt = st_r.tm[2];
		if (st_r.ctrl[RTC_BIT_H12])
		begin
			if (st_r.tm[2][4:0] == 5'h12)
				h_nxt = {st_r.tm[2][7:5], 5'h01}; // R6
			else if (st_r.tm[2][4:0] == 5'h11)
			begin
				h_nxt = {st_r.tm[2][7:6], ~st_r.tm[2][RTC_BIT_PM], 5'h12}; // R6
				h_carry = st_r.tm[2][RTC_BIT_PM];
			end
			else
				h_nxt = {st_r.tm[2][7:5], h12_inc[4:0]};
		end
		else
			{h_carry, h_nxt} = bcd_inc(st_r.tm[2], 8'h23, 8'h00);

		// Time base: oscillator ticks make seconds
		if (osc_rise)
			st_nxt.tick = sec_done ? 16'h0000 : st_r.tick + 16'h0001;
		if (sec_done)
		begin
			st_nxt.pend = 1'b1;
			if (st_r.corr == (st_r.freq[RTC_BIT_MODE] ? CORR1_LAST
				: CORR0_LAST) || st_r.corr > CORR0_LAST)
			begin
				st_nxt.corr = 13'h0000; // R13 R14
				st_nxt.fix = 1'b1;
			end
			else
			begin
				st_nxt.corr = st_r.corr + 13'h0001;
				st_nxt.fix = 1'b0;
			end
		end
		if (inc_now)
		begin
			st_nxt.pend = sec_done;
			if (st_r.tm[0][6:0] == 7'h59)
			begin
				st_nxt.tm[0][6:0] = 7'h00;
				st_nxt.tm[1] = c_min[7:0];
				if (c_min[8])
				begin
					st_nxt.tm[2] = h_nxt;
					if (h_carry)
					begin
						st_nxt.tm[3] = c_day[7:0];
						st_nxt.tm[4] = st_r.tm[4] == 8'h06 ? 8'h00
							: st_r.tm[4] + 8'h01; // R10
						if (c_day[8])
						begin
							st_nxt.tm[5] = c_mon[7:0];
							if (c_mon[8])
								st_nxt.tm[6] = c_yr[7:0];
						end
					end
				end
			end
			else
				st_nxt.tm[0][6:0] = sec_inc[6:0];
		end

		// Bus target
		if (scl_rise && (st_r.state == RTC_ADDR || st_r.state == RTC_WDATA))
		begin
			st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s[1]};
			st_nxt.bitcnt = st_r.bitcnt + 4'd1;
		end
		case (st_r.state)
			RTC_ADDR:
				if (scl_fall && st_r.bitcnt == 4'd8)
				begin
					if (st_r.shreg[7:1] == RTC_DEV_ADDR)
					begin
						st_nxt.state = RTC_ADDR_ACK; // R1 R7
						st_nxt.drv = 1'b1; // R18
					end
					else
						st_nxt.state = RTC_IDLE;
				end
			RTC_ADDR_ACK:
				if (scl_fall)
				begin
					st_nxt.bitcnt = 4'd0;
					if (st_r.shreg[0])
					begin
						st_nxt.state = RTC_RDATA; // R7
						st_nxt.shreg = {rd_byte[6:0], 1'b0};
						st_nxt.drv = ~rd_byte[7];
						st_nxt.bitcnt = 4'd1;
					end
					else
					begin
						st_nxt.state = RTC_WDATA;
						st_nxt.drv = 1'b0;
						st_nxt.first = 1'b1;
					end
				end
			RTC_WDATA:
				if (scl_fall && st_r.bitcnt == 4'd8)
				begin
					st_nxt.state = RTC_WACK;
					st_nxt.drv = 1'b1; // R18
					st_nxt.first = 1'b0;
					if (st_r.first)
						st_nxt.ptr = st_r.shreg[4:0]; // R1
					else
					begin
						st_nxt.ptr = st_r.ptr + 5'd1; // R4
						if (st_r.ptr == RTC_OFS_CONTROL)
							st_nxt.ctrl = st_r.shreg; // R2 R3
						else if (st_r.ptr == RTC_OFS_FREQ)
							st_nxt.freq = st_r.shreg; // R11
						else if (st_r.ptr >= RTC_OFS_SECONDS
							&& st_r.ptr <= RTC_OFS_YEAR)
							st_nxt.tm[3'(st_r.ptr - RTC_OFS_SECONDS)] =
								st_r.shreg; // R4 R5
					end
				end
			RTC_WACK:
				if (scl_fall)
				begin
					st_nxt.state = RTC_WDATA;
					st_nxt.drv = 1'b0;
					st_nxt.bitcnt = 4'd0;
				end
			RTC_RDATA:
				if (scl_fall)
				begin
					if (st_r.bitcnt == 4'd8)
					begin
						st_nxt.state = RTC_RACK;
						st_nxt.drv = 1'b0;
						st_nxt.ptr = st_r.ptr + 5'd1; // R8
					end
					else
					begin
						st_nxt.drv = ~st_r.shreg[7];
						st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
						st_nxt.bitcnt = st_r.bitcnt + 4'd1;
					end
				end
			RTC_RACK:
				if (scl_rise)
					st_nxt.nack = st_r.sda_s[1];
				else if (scl_fall)
				begin
					if (st_r.nack)
						st_nxt.state = RTC_IDLE; // R18
					else
					begin
						st_nxt.state = RTC_RDATA; // R8
						st_nxt.shreg = {rd_byte[6:0], 1'b0};
						st_nxt.drv = ~rd_byte[7];
						st_nxt.bitcnt = 4'd1;
					end
				end
			default:
				st_nxt.drv = 1'b0;
		endcase
		// A start or stop overrides any byte in flight
		if (start_c)
		begin
			st_nxt.state = RTC_ADDR;
			st_nxt.bitcnt = 4'd0;
			st_nxt.drv = 1'b0;
			st_nxt.busy = 1'b1; // R16
		end
		else if (stop_c)
		begin
			st_nxt.state = RTC_IDLE;
			st_nxt.drv = 1'b0;
			st_nxt.busy = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
			st_r.scl_s <= 3'b111;
			st_r.sda_s <= 3'b111;
			st_r.ctrl <= RTC_RST_CONTROL;
			st_r.freq <= RTC_RST_FREQ;
			st_r.tm[0] <= RTC_RST_SECONDS;
			st_r.tm[1] <= RTC_RST_ZERO;
			st_r.tm[2] <= RTC_RST_ZERO;
			st_r.tm[3] <= RTC_RST_DAY;
			st_r.tm[4] <= RTC_RST_ZERO;
			st_r.tm[5] <= RTC_RST_MONTH;
			st_r.tm[6] <= RTC_RST_ZERO;
		end
		else
			st_r <= st_nxt;
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = ~st_r.drv;
	assign oscillator_output_pin_o = st_r.clk_out;
	assign hour12_mode_o = st_r.ctrl[RTC_BIT_H12]; // R2 R3
	assign cap_sel_o = st_r.ctrl[RTC_BIT_CAP]; // R2 R3

	// ****************************************
	// Checks
	// ****************************************
	a_addr_ack: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R18
		st_r.state == RTC_ADDR && scl_fall && st_r.bitcnt == 4'd8
		&& st_r.shreg[7:1] == RTC_DEV_ADDR && !start_c && !stop_c
		|=> st_r.state == RTC_ADDR_ACK && !sda_oe_o)
		else $error("address not acknowledged");
	a_write_ctrl: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
		wr_en && st_r.ptr == RTC_OFS_CONTROL && !start_c && !stop_c
		|=> hour12_mode_o == $past(st_r.shreg[1])
		&& cap_sel_o == $past(st_r.shreg[0]))
		else $error("control bits not taken");
	a_flag_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
		wr_en && st_r.ptr == RTC_OFS_SECONDS && !st_r.shreg[7]
		&& !start_c && !stop_c
		|=> !st_r.tm[0][RTC_BIT_FLAG])
		else $error("integrity flag not cleared");
	a_freeze_time: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R16
		st_r.busy && !wr_en |=> $stable(st_r.tm))
		else $error("time moved during access");
	a_pend_apply: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R16
		inc_now |=> st_r.tm[0][6:0] != $past(st_r.tm[0][6:0]))
		else $error("pending second not applied");
	a_read_adv: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
		st_r.state == RTC_RDATA && scl_fall && st_r.bitcnt == 4'd8
		&& !start_c && !stop_c
		|=> st_r.ptr == $past(st_r.ptr) + 5'd1 && sda_oe_o)
		else $error("read pointer not advanced");
	a_nack_end: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R18
		st_r.state == RTC_RACK && scl_fall && st_r.nack && !start_c
		|=> st_r.state == RTC_IDLE && sda_oe_o)
		else $error("burst went on after NACK");
	a_pm_toggle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
		inc_now && st_r.ctrl[RTC_BIT_H12] && st_r.tm[0][6:0] == 7'h59
		&& st_r.tm[1] == 8'h59 && st_r.tm[2][4:0] == 5'h11
		|=> st_r.tm[2][RTC_BIT_PM] != $past(st_r.tm[2][RTC_BIT_PM])
		&& st_r.tm[2][4:0] == 5'h12)
		else $error("PM bit not toggled at 12");
	a_corr_range: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13 R14
		sec_done && st_r.corr == (st_r.freq[RTC_BIT_MODE] ? CORR1_LAST
		: CORR0_LAST) |=> st_r.fix && st_r.corr == 13'h0000)
		else $error("correction second not selected");
	a_clk_out: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R15
		osc_rise |=> oscillator_output_pin_o ##1 oscillator_output_pin_o
		== $past(st_r.osc_s[1]))
		else $error("clock output does not follow oscillator");
endmodule : rtc_core

// [test/rtc_host_model.sv]
// Behavioural I2C bus controller facing the clock core
`timescale 1ns/1ps
module rtc_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	logic [7:0] rbuf [0:15];
	int nacks;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		nacks = 0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : w
	// SDA moves one cycle into the low phase so its hold never races SCL
	task automatic bitx(input logic b, output logic v);
		sda_o = b;
		w(3);
		scl_o = 1'b1;
		w(2);
		v = sda_i;
		w(2);
		scl_o = 1'b0;
		w(1);
	endtask : bitx
	task automatic start_c;
		sda_o = 1'b1;
		w(2);
		scl_o = 1'b1;
		w(4);
		sda_o = 1'b0;
		w(4);
		scl_o = 1'b0;
		w(1);
	endtask : start_c
	task automatic stop_c;
		sda_o = 1'b0;
		w(3);
		scl_o = 1'b1;
		w(4);
		sda_o = 1'b1;
		w(4);
	endtask : stop_c
	task automatic wbyte(input logic [7:0] d);
		logic v;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], v);
		bitx(1'b1, v);
		if (v !== 1'b0)
			nacks++;
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic v;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, v);
			d[i] = v;
		end
		bitx(last, v);
	endtask : rbyte
	task automatic probe(input logic [7:0] a);
		start_c;
		wbyte(a);
		stop_c;
	endtask : probe
	// Accesses of up to ten bytes stay below one second of the core's time base
	task automatic wr_regs(input logic [7:0] p, input logic [63:0] d,
		input int n);
		start_c;
		wbyte(8'ha2);
		wbyte(p);
		for (int i = 0; i < n; i++)
			wbyte(d[63 - 8 * i -: 8]);
		stop_c;
	endtask : wr_regs
	task automatic rd_regs(input logic [7:0] p, input int n);
		start_c;
		wbyte(8'ha2);
		wbyte(p);
		start_c;
		wbyte(8'ha3);
		for (int i = 0; i < n; i++)
			rbyte(i == n - 1, rbuf[i]);
		stop_c;
	endtask : rd_regs
endmodule : rtc_host_model

// [test/tb.sv]
// Self-checking bench of the clock core with a bus controller model
`timescale 1ns/1ps
module tb;
	import rtc_pkg::*;
	localparam int TPS = 64;
	localparam int SEC_CLK = TPS * 16;
	logic clk_i, sys_rst_i, osc_i, scl_w, host_sda;
	logic sda_o, sda_drive_n, osc_pin, h12, cap;
	wire logic sda_w;
	int fails, checked, cycles;
	assign sda_w = host_sda & (sda_drive_n | sda_o);
	rtc_core #(.TICKS_PER_SEC(TPS), .CORR_MODE0_SEC(6),
		.CORR_MODE1_SEC(3)) u_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_drive_n),
		.osc_i(osc_i), .oscillator_output_pin_o(osc_pin),
		.hour12_mode_o(h12), .cap_sel_o(cap));
	rtc_host_model u_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w),
		.sda_o(host_sda));
	// ****************************************
	// Clocks and checking
	// ****************************************
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Oscillator kept fast so a whole run fits; seconds come from TPS
	initial
	begin
		osc_i = 1'b0;
		#6;
		forever #80 osc_i = ~osc_i;
	end
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk8
	task automatic chkr(input logic [31:0] g, input int lo, input int hi);
		checked++;
		if ($isunknown(g) || int'(g) < lo || int'(g) > hi)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h..%h", $time, g, lo, hi);
		end
	endtask : chkr
	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			fails++;
			complete_run;
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [7:0] e [0:10];
		e = '{RTC_RST_CONTROL, 8'h00, RTC_RST_FREQ, 8'h00, RTC_RST_SECONDS,
			RTC_RST_ZERO, RTC_RST_ZERO, RTC_RST_DAY, RTC_RST_ZERO,
			RTC_RST_MONTH, RTC_RST_ZERO};
		u_host.rd_regs(8'h00, 11);
		for (int i = 0; i < 11; i++)
			chk8(u_host.rbuf[i], e[i]);
		chk8({7'h0, h12}, 8'h00);
		chk8({7'h0, cap}, 8'h00);
		u_host.probe(8'ha4);
		chkr(u_host.nacks, 1, 1);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_ctrl;
		u_host.wr_regs(8'h00, 64'h03 << 56, 1);
		chk8({7'h0, cap}, 8'h01);
		chk8({7'h0, h12}, 8'h01);
		u_host.wr_regs(8'h00, 64'h02 << 56, 1);
		chk8({7'h0, cap}, 8'h00);
		chk8({7'h0, h12}, 8'h01);
		$display("t_ctrl done");
	endtask : t_ctrl
	task automatic t_set;
		logic [63:0] d;
		d = 64'h00_45_23_15_04_12_11_00;
		u_host.wr_regs(8'h04, d, 7);
		chkr(u_host.nacks, 1, 1);
		u_host.w(SEC_CLK / 2);
		u_host.rd_regs(8'h04, 7);
		chk8(u_host.rbuf[0] & 8'h80, 8'h00);
		chkr({24'h000000, u_host.rbuf[0]}, 0, 2);
		for (int i = 1; i < 7; i++)
			chk8(u_host.rbuf[i], d[63 - 8 * i -: 8]);
		chk8(u_host.rbuf[2], 8'h23);
		chk8(u_host.rbuf[3], 8'h15);
		chk8(u_host.rbuf[4], 8'h04);
		$display("t_set done");
	endtask : t_set
	// Eleven PM on the 28th of February rolls over to the next day
	task automatic t_roll(input logic [7:0] yr, input logic [7:0] dy,
		input logic [7:0] mo);
		u_host.wr_regs(8'h04, {8'h59, 8'h59, 8'h31, 8'h28, 8'h04, 8'h02,
			yr, 8'h00}, 7);
		u_host.w(2 * SEC_CLK);
		u_host.rd_regs(8'h04, 7);
		chk8(u_host.rbuf[1], 8'h00);
		chk8(u_host.rbuf[2], 8'h12);
		chk8(u_host.rbuf[3], dy);
		chk8(u_host.rbuf[4], 8'h05);
		chk8(u_host.rbuf[5], mo);
		chk8(u_host.rbuf[6], yr);
		$display("t_roll done");
	endtask : t_roll
	// Counts seconds over a window; bounds allow for interval phase
	task automatic t_corr(input logic [7:0] f, input int win, input int lo,
		input int hi);
		logic [31:0] el;
		u_host.wr_regs(8'h02, {f, 56'h0}, 1);
		u_host.wr_regs(8'h04, 64'h0, 1);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge osc_i);
			u_host.w(6);
			chk8({7'h0, osc_pin}, {7'h0, osc_i});
		end
		u_host.w(win * SEC_CLK - 400);
		u_host.rd_regs(8'h04, 1);
		el = 32'(u_host.rbuf[0][6:4]) * 32'h0000000a
			+ 32'(u_host.rbuf[0][3:0]);
		chkr(el, lo, hi);
		$display("t_corr done");
	endtask : t_corr
	initial
	begin
		fails = 0;
		checked = 0;
		cycles = 0;
		sys_rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		u_host.w(4);
		t_reset;
		t_ctrl;
		t_set;
		t_roll(8'h12, 8'h29, 8'h02);
		t_roll(8'h11, 8'h01, 8'h03);
		t_corr(8'hbf, 24, 30, 37);
		t_corr(8'h40, 30, 24, 28);
		complete_run;
	end
endmodule : tb
